// ### design/radio_irq_pkg.sv
// Constants, field layouts, enumerations and carrier types of the radio event block.
// Assumes a single 20 MHz clock and an APB master with 32-bit data and 8-bit addresses.
package radio_irq_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 50;
   localparam int XTAL_STAB_MIN_NS = 300000;
   localparam int TCXO_STAB_MIN_NS = 10000;
   localparam int VCO_CAL_NS = 9000000;
   localparam int TX_FROM_IDLE_NS = 143000;
   localparam int TX_FROM_RX_NS = 24000;
   localparam int RX_FROM_IDLE_NS = 118000;
   localparam int RX_FROM_TX_NS = 25000;
   localparam int OFF_FROM_TX_NS = 24000;
   localparam int OFF_FROM_RX_NS = 5000;
   localparam int RF_WAKE_NS = 210000;

   function automatic int cyc_ceil(input int ns);
      return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   endfunction

   localparam int XTAL_STAB_CYC_DEF = cyc_ceil(XTAL_STAB_MIN_NS);
   localparam int VCO_CAL_CYC_DEF = cyc_ceil(VCO_CAL_NS);
   localparam int RF_WAKE_CYC_DEF = cyc_ceil(RF_WAKE_NS);
   localparam logic [23:0] TCXO_STAB_LD = 24'(cyc_ceil(TCXO_STAB_MIN_NS) - 1);
   localparam logic [23:0] TX_FROM_IDLE_LD = 24'(cyc_ceil(TX_FROM_IDLE_NS) - 1);
   localparam logic [23:0] TX_FROM_RX_LD = 24'(cyc_ceil(TX_FROM_RX_NS) - 1);
   localparam logic [23:0] RX_FROM_IDLE_LD = 24'(cyc_ceil(RX_FROM_IDLE_NS) - 1);
   localparam logic [23:0] RX_FROM_TX_LD = 24'(cyc_ceil(RX_FROM_TX_NS) - 1);
   localparam logic [23:0] OFF_FROM_TX_LD = 24'(cyc_ceil(OFF_FROM_TX_NS) - 1);
   localparam logic [23:0] OFF_FROM_RX_LD = 24'(cyc_ceil(OFF_FROM_RX_NS) - 1);

   // ----------------------------------------------------------------
   // Register map and fields
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_SRC_A = 8'h00;
   localparam logic [7:0] OFS_SRC_B = 8'h04;
   localparam logic [7:0] OFS_SRC_C = 8'h08;
   localparam logic [7:0] OFS_EN_A = 8'h0c;
   localparam logic [7:0] OFS_EN_B = 8'h10;
   localparam logic [7:0] OFS_EN_C = 8'h14;
   localparam logic [7:0] OFS_CTRL = 8'h18;
   localparam logic [7:0] OFS_CMD = 8'h1c;
   localparam logic [7:0] OFS_WAKE = 8'h20;
   localparam logic [7:0] OFS_CAL = 8'h24;
   localparam int CTRL_TCXO_BIT = 0;
   localparam int CTRL_FMT_LSB = 1;
   localparam int CTRL_EMPTY_LSB = 8;
   localparam int CTRL_FULL_LSB = 16;
   localparam logic [31:0] CTRL_WMASK = 32'h00ff_ff07;
   localparam logic [31:0] CTRL_RST = 32'h0005_0200;
   localparam logic [15:0] WAKE_RST = 16'h0064;
   localparam logic [15:0] CAL_RST = 16'h0064;
   localparam logic [1:0] FMT_A = 2'h0;
   localparam logic [1:0] FMT_B = 2'h1;
   localparam logic [1:0] FMT_C = 2'h2;

   localparam logic [3:0] CMD_TX_ON = 4'h1;
   localparam logic [3:0] CMD_RX_ON = 4'h2;
   localparam logic [3:0] CMD_RADIO_OFF = 4'h3;
   localparam logic [3:0] CMD_FORCED_OFF = 4'h4;
   localparam logic [3:0] CMD_SLEEP = 4'h5;
   localparam logic [3:0] CMD_SLEEP_EXIT = 4'h6;
   localparam logic [3:0] CMD_VCO_CAL = 4'h7;
   localparam logic [3:0] CMD_CLK_CAL = 4'h8;
   localparam logic [3:0] CMD_REF_OSC = 4'h9;

   localparam int EV_CLK_STAB = 0;
   localparam int EV_VCO_CAL = 1;
   localparam int EV_PLL = 2;
   localparam int EV_RF_DONE = 3;
   localparam int EV_EMPTY = 4;
   localparam int EV_FULL = 5;
   localparam int EV_WAKE = 6;
   localparam int EV_CLK_CAL = 7;
   localparam int EV_RX_DONE = 8;
   localparam int EV_CRC = 9;
   localparam logic [23:0] EV_IMPL_MASK = 24'h0003ff;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      RF_IDLE = 4'b0001,
      RF_TX = 4'b0010,
      RF_RX = 4'b0100,
      RF_SLEEP = 4'b1000
   } rf_state_type;

   typedef enum logic [2:0] {
      RXP_OFF = 3'b001,
      RXP_LEN = 3'b010,
      RXP_DATA = 3'b100
   } rx_phase_type;

   typedef struct packed {
      logic pll_unlock;
      logic vco_range_bad;
      logic power_amp_on;
      logic rx_enable;
      logic sync_detect;
      logic rx_bit_tick;
      logic rx_bit;
      logic crc_block_done;
      logic crc_ok;
      logic host_fifo_read;
      logic host_fifo_write;
      logic [6:0] fifo_level;
   } radio_in_type;

   typedef struct packed {
      logic [23:0] src;
      logic [23:0] en;
      logic [31:0] ctrl;
      logic [15:0] wake_per;
      logic [15:0] cal_per;
      logic [31:0] prdata;
      logic pslverr;
      logic notify_n;
      rf_state_type rf;
      rf_state_type tgt;
      logic [23:0] trans_cnt;
      logic [23:0] stab_cnt;
      logic [23:0] vco_cnt;
      logic [23:0] wake_cnt;
      logic [23:0] cal_cnt;
      logic [23:0] txw_cnt;
      logic tx_stream;
      logic empty_seen;
      rx_phase_type rxp;
      logic [7:0] rx_len;
      logic [10:0] rx_rem;
      logic [15:0] rx_bits;
      logic full_seen;
      logic pa_q;
      logic rxen_q;
   } irq_state_type;

endpackage

// ### design/radio_irq_event.sv
// Event latching, timing and notification logic of the radio, with an APB register slave.
// Assumes radio status inputs come from logic on pclk and the APB master runs on pclk.
`timescale 1ns/1ps
module radio_irq_event
   import radio_irq_pkg::*;
#(
   parameter int XTAL_STAB_CYC = XTAL_STAB_CYC_DEF,
   parameter int VCO_CAL_CYC = VCO_CAL_CYC_DEF,
   parameter int RF_WAKE_CYC = RF_WAKE_CYC_DEF
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire radio_in_type rin,
   output logic irq_notify_n,
   output logic irq,
   output rf_state_type rf_state
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   localparam logic [23:0] XTAL_STAB_LD = 24'(XTAL_STAB_CYC - 1);
   localparam logic [23:0] VCO_CAL_LD = 24'(VCO_CAL_CYC - 1);
   localparam logic [23:0] RF_WAKE_LD = 24'(RF_WAKE_CYC - 1);
   localparam irq_state_type ST_RST = '{
      ctrl: CTRL_RST,
      wake_per: WAKE_RST,
      cal_per: CAL_RST,
      notify_n: 1'b1,
      rf: RF_IDLE,
      tgt: RF_IDLE,
      stab_cnt: XTAL_STAB_LD,
      rxp: RXP_OFF,
      default: '0
   };

   irq_state_type s;
   irq_state_type n;
   logic wr_acc;
   logic cmd_wr;
   logic [3:0] cmd_code;
   logic armed;
   logic range_fire;
   logic rx_done;
   logic [23:0] ev;
   logic [23:0] clr_vec;
   logic [23:0] keep_vec;
   logic [23:0] gone_vec;
   logic [23:0] stab_load;
   logic [7:0] empty_lvl;
   logic [7:0] full_lvl;
   logic [1:0] fmt;
   logic [7:0] len_next;

   function automatic logic [23:0] dec(input logic [23:0] c);
      return (c == 24'h0) ? 24'h0 : c - 24'h1;
   endfunction

   function automatic logic fires(input logic [23:0] c);
      return c == 24'h1;
   endfunction

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   assign pready = 1'b1;
   assign prdata = s.prdata;
   assign pslverr = s.pslverr;
   assign irq_notify_n = s.notify_n;
   assign irq = ~s.notify_n;
   assign rf_state = s.rf;
   assign wr_acc = psel & penable & pwrite;
   assign cmd_wr = wr_acc & (paddr == OFS_CMD);
   assign cmd_code = pwdata[3:0];
   assign empty_lvl = s.ctrl[CTRL_EMPTY_LSB +: 8];
   assign full_lvl = s.ctrl[CTRL_FULL_LSB +: 8];
   assign fmt = s.ctrl[CTRL_FMT_LSB +: 2];
   assign stab_load = s.ctrl[CTRL_TCXO_BIT] ? TCXO_STAB_LD : XTAL_STAB_LD;
   assign len_next = {s.rx_len[6:0], rin.rx_bit};
   assign armed = ((s.rf == RF_TX) && rin.power_amp_on) ||
                  ((s.rf == RF_RX) && rin.rx_enable);
   assign range_fire = rin.vco_range_bad &&
                       (((s.rf == RF_TX) && rin.power_amp_on && !s.pa_q) ||
                        ((s.rf == RF_RX) && rin.rx_enable && !s.rxen_q));
   assign keep_vec = s.src & ~clr_vec;
   assign gone_vec = clr_vec & ~ev;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      n = s;
      ev = 24'h0;
      clr_vec = 24'h0;
      rx_done = 1'b0;
      if (wr_acc) begin
         case (paddr)
            OFS_SRC_A: clr_vec[7:0] = pwdata[7:0];
            OFS_SRC_B: clr_vec[15:8] = pwdata[7:0];
            OFS_SRC_C: clr_vec[23:16] = pwdata[7:0];
            OFS_EN_A: n.en[7:0] = pwdata[7:0] & EV_IMPL_MASK[7:0];
            OFS_EN_B: n.en[15:8] = pwdata[7:0] & EV_IMPL_MASK[15:8];
            OFS_EN_C: n.en[23:16] = pwdata[7:0] & EV_IMPL_MASK[23:16];
            OFS_CTRL: n.ctrl = pwdata & CTRL_WMASK;
            OFS_WAKE: n.wake_per = pwdata[15:0];
            OFS_CAL: n.cal_per = pwdata[15:0];
            default: ;
         endcase
      end
      if (psel && !penable) begin
         n.pslverr = 1'b0;
         case (paddr)
            OFS_SRC_A: n.prdata = {24'h0, s.src[7:0]};
            OFS_SRC_B: n.prdata = {24'h0, s.src[15:8]};
            OFS_SRC_C: n.prdata = {24'h0, s.src[23:16]};
            OFS_EN_A: n.prdata = {24'h0, s.en[7:0]};
            OFS_EN_B: n.prdata = {24'h0, s.en[15:8]};
            OFS_EN_C: n.prdata = {24'h0, s.en[23:16]};
            OFS_CTRL: n.prdata = s.ctrl;
            OFS_CMD: n.prdata = {22'h0, s.rxp, s.trans_cnt != 24'h0,
                                 s.stab_cnt != 24'h0, s.vco_cnt != 24'h0, s.rf};
            OFS_WAKE: n.prdata = {16'h0, s.wake_per};
            OFS_CAL: n.prdata = {16'h0, s.cal_per};
            default: begin
               n.prdata = 32'h0;
               n.pslverr = 1'b1;
            end
         endcase
      end

      // Timers.
      n.trans_cnt = dec(s.trans_cnt);
      if (fires(s.trans_cnt)) begin
         n.rf = s.tgt;
         ev[EV_RF_DONE] = 1'b1;
      end
      n.stab_cnt = dec(s.stab_cnt);
      if (fires(s.stab_cnt)) begin
         ev[EV_CLK_STAB] = 1'b1;
      end
      n.vco_cnt = dec(s.vco_cnt);
      if (fires(s.vco_cnt)) begin
         ev[EV_VCO_CAL] = 1'b1;
      end
      n.wake_cnt = dec(s.wake_cnt);
      if (fires(s.wake_cnt)) begin
         ev[EV_WAKE] = 1'b1;
         n.rf = RF_IDLE;
         n.stab_cnt = stab_load;
      end
      n.cal_cnt = dec(s.cal_cnt);
      if (fires(s.cal_cnt)) begin
         ev[EV_CLK_CAL] = 1'b1;
      end
      n.txw_cnt = dec(s.txw_cnt);
      if (fires(s.txw_cnt)) begin
         n.tx_stream = 1'b1;
      end

      // Commands.
      if (cmd_wr) begin
         case (cmd_code)
            CMD_TX_ON: begin
               if (s.trans_cnt == 24'h0 && (s.rf == RF_IDLE || s.rf == RF_RX)) begin
                  n.tgt = RF_TX;
                  n.trans_cnt = (s.rf == RF_IDLE) ? TX_FROM_IDLE_LD : TX_FROM_RX_LD;
                  n.txw_cnt = RF_WAKE_LD;
                  n.tx_stream = 1'b0;
                  n.empty_seen = 1'b0;
               end
            end
            CMD_RX_ON: begin
               if (s.trans_cnt == 24'h0 && (s.rf == RF_IDLE || s.rf == RF_TX)) begin
                  n.tgt = RF_RX;
                  n.trans_cnt = (s.rf == RF_IDLE) ? RX_FROM_IDLE_LD : RX_FROM_TX_LD;
                  n.txw_cnt = 24'h0;
                  n.tx_stream = 1'b0;
               end
            end
            CMD_RADIO_OFF, CMD_FORCED_OFF: begin
               if ((s.trans_cnt == 24'h0 || cmd_code == CMD_FORCED_OFF) &&
                   (s.rf == RF_TX || s.rf == RF_RX)) begin
                  n.tgt = RF_IDLE;
                  n.trans_cnt = (s.rf == RF_TX) ? OFF_FROM_TX_LD : OFF_FROM_RX_LD;
                  n.txw_cnt = 24'h0;
                  n.tx_stream = 1'b0;
               end
            end
            CMD_SLEEP: begin
               if (s.trans_cnt == 24'h0 && s.rf == RF_IDLE) begin
                  n.rf = RF_SLEEP;
                  n.wake_cnt = {8'h0, s.wake_per};
               end
            end
            CMD_SLEEP_EXIT: begin
               if (s.rf == RF_SLEEP) begin
                  n.rf = RF_IDLE;
                  n.wake_cnt = 24'h0;
                  n.stab_cnt = stab_load;
               end
            end
            CMD_VCO_CAL: n.vco_cnt = VCO_CAL_LD;
            CMD_CLK_CAL: n.cal_cnt = {8'h0, s.cal_per};
            CMD_REF_OSC: begin
               if (s.ctrl[CTRL_TCXO_BIT]) begin
                  n.stab_cnt = TCXO_STAB_LD;
               end
            end
            default: ;
         endcase
      end

      // Synthesizer events.
      if (armed && rin.pll_unlock) begin
         ev[EV_PLL] = 1'b1;
      end
      if (range_fire) begin
         ev[EV_PLL] = 1'b1;
      end
      n.pa_q = rin.power_amp_on;
      n.rxen_q = rin.rx_enable;

      // FIFO level events.
      if (s.tx_stream && s.rf == RF_TX && !s.empty_seen && {1'b0, rin.fifo_level} <= empty_lvl) begin
         ev[EV_EMPTY] = 1'b1;
         n.empty_seen = 1'b1;
      end
      if (rin.host_fifo_read && s.rf == RF_RX && {1'b0, rin.fifo_level} < empty_lvl) begin
         ev[EV_EMPTY] = 1'b1;
      end
      if (rin.host_fifo_write && {1'b0, rin.fifo_level} > full_lvl) begin
         ev[EV_FULL] = 1'b1;
      end

      // Receive framing from the sync word.
      if (s.rf != RF_RX) begin
         n.rxp = RXP_OFF;
      end else if (rin.sync_detect) begin
         n.rxp = RXP_LEN;
         n.rx_bits = 16'h0;
         n.rx_len = 8'h0;
         n.full_seen = 1'b0;
      end else if (rin.rx_bit_tick && s.rxp != RXP_OFF) begin
         n.rx_bits = s.rx_bits + 16'h1;
         if (!s.full_seen && full_lvl != 8'h0 && n.rx_bits == {5'h0, full_lvl, 3'h0}) begin
            ev[EV_FULL] = 1'b1;
            n.full_seen = 1'b1;
         end
         case (s.rxp)
            RXP_LEN: begin
               n.rx_len = len_next;
               if (s.rx_bits[2:0] == 3'h7) begin
                  if (len_next == 8'h0) begin
                     rx_done = 1'b1;
                  end else begin
                     n.rxp = RXP_DATA;
                     n.rx_rem = {len_next, 3'h0};
                  end
               end
            end
            RXP_DATA: begin
               n.rx_rem = s.rx_rem - 11'h1;
               if (s.rx_rem == 11'h1) begin
                  rx_done = 1'b1;
               end
            end
            default: ;
         endcase
      end
      if (rx_done) begin
         n.rxp = RXP_OFF;
         ev[EV_RX_DONE] = 1'b1;
         if (fmt == FMT_C && !rin.crc_ok) begin
            ev[EV_CRC] = 1'b1;
         end
      end
      if (s.rf == RF_RX && s.rxp != RXP_OFF && rin.crc_block_done && !rin.crc_ok &&
          fmt != FMT_C) begin
         ev[EV_CRC] = 1'b1;
      end

      // Pending events and notification.
      n.src = ((s.src & ~clr_vec) | ev) & EV_IMPL_MASK;
      n.notify_n = ~|(n.src & n.en);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= ST_RST;
      end else begin
         s <= n;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   property p_pending_hold;
      @(posedge pclk) disable iff (!presetn)
      1'b1 |=> ((s.src & $past(keep_vec)) == $past(keep_vec));
   endproperty
   a_pending_hold: assert property (p_pending_hold) else $error("pending event lost");

   property p_enable_notify;
      @(posedge pclk) disable iff (!presetn)
      (|(s.src & ~s.en & n.en & ~clr_vec)) |=> !irq_notify_n;
   endproperty
   a_enable_notify: assert property (p_enable_notify) else $error("no notify on enable");

   property p_notify_level;
      @(posedge pclk) disable iff (!presetn)
      irq_notify_n == ~|(s.src & s.en);
   endproperty
   a_notify_level: assert property (p_notify_level) else $error("notify line mismatch");

   property p_clear_next;
      @(posedge pclk) disable iff (!presetn)
      1'b1 |=> ((s.src & $past(gone_vec)) == 24'h0);
   endproperty
   a_clear_next: assert property (p_clear_next) else $error("cleared event stays");

   property p_tcxo_stab;
      @(posedge pclk) disable iff (!presetn)
      (cmd_wr && cmd_code == CMD_REF_OSC && s.ctrl[CTRL_TCXO_BIT]) |-> ##200 s.src[EV_CLK_STAB];
   endproperty
   a_tcxo_stab: assert property (p_tcxo_stab) else $error("clock stable late");

   sequence s_rx_off_req;
      cmd_wr && cmd_code == CMD_RADIO_OFF && s.rf == RF_RX && s.trans_cnt == 24'h0;
   endsequence
   sequence s_rx_off_done;
      ##99 (s.rf == RF_RX) ##1 (s.rf == RF_IDLE && s.src[EV_RF_DONE]);
   endsequence
   property p_rx_off;
      @(posedge pclk) disable iff (!presetn)
      s_rx_off_req |-> s_rx_off_done;
   endproperty
   a_rx_off: assert property (p_rx_off) else $error("radio off timing wrong");

   property p_pll_arm;
      @(posedge pclk) disable iff (!presetn)
      (armed && rin.pll_unlock) |=> s.src[EV_PLL];
   endproperty
   a_pll_arm: assert property (p_pll_arm) else $error("unlock not latched");

   property p_pll_quiet;
      @(posedge pclk) disable iff (!presetn)
      (!armed && !range_fire && !s.src[EV_PLL]) |=> !s.src[EV_PLL];
   endproperty
   a_pll_quiet: assert property (p_pll_quiet) else $error("unlock while unarmed");

   property p_range_edge;
      @(posedge pclk) disable iff (!presetn)
      (s.rf == RF_TX && rin.power_amp_on && !s.pa_q && rin.vco_range_bad) |=> s.src[EV_PLL];
   endproperty
   a_range_edge: assert property (p_range_edge) else $error("range check missed");

   property p_fifo_write;
      @(posedge pclk) disable iff (!presetn)
      (rin.host_fifo_write && {1'b0, rin.fifo_level} > full_lvl) |=> s.src[EV_FULL];
   endproperty
   a_fifo_write: assert property (p_fifo_write) else $error("full level missed");

   property p_rx_done;
      @(posedge pclk) disable iff (!presetn)
      rx_done |=> (s.src[EV_RX_DONE] && s.rxp == RXP_OFF);
   endproperty
   a_rx_done: assert property (p_rx_done) else $error("receive done missed");

   property p_crc_block;
      @(posedge pclk) disable iff (!presetn)
      (s.rf == RF_RX && s.rxp != RXP_OFF && rin.crc_block_done && !rin.crc_ok && fmt != FMT_C)
         |=> s.src[EV_CRC];
   endproperty
   a_crc_block: assert property (p_crc_block) else $error("block crc missed");

   property p_crc_fmt_c;
      @(posedge pclk) disable iff (!presetn)
      (rx_done && fmt == FMT_C && !rin.crc_ok) |=> s.src[EV_CRC];
   endproperty
   a_crc_fmt_c: assert property (p_crc_fmt_c) else $error("format c crc missed");

   property p_wake;
      @(posedge pclk) disable iff (!presetn)
      (s.rf == RF_SLEEP && s.wake_cnt == 24'h1) |=> (s.src[EV_WAKE] && s.rf == RF_IDLE);
   endproperty
   a_wake: assert property (p_wake) else $error("wake event missed");

endmodule

// ### tb/host_irq_watch.sv
// Host-side model that watches the notification line and counts notifications.
// Assumes irq_notify_n is registered on pclk and presetn is the async reset.
`timescale 1ns/1ps
module host_irq_watch (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic irq_notify_n,
   output logic [7:0] notify_count
);
   logic line_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         line_r <= 1'b1;
         notify_count <= 8'h00;
      end else begin
         line_r <= irq_notify_n;
         if (line_r && !irq_notify_n) begin
            notify_count <= notify_count + 8'h01;
         end
      end
   end
endmodule

// ### tb/test_radio_irq_event.sv
// Self-checking testbench of the radio event block with an APB host.
// Assumes the package radio_irq_pkg and short timing parameters.
`timescale 1ns/1ps
module test_radio_irq_event import radio_irq_pkg::*; ;
   localparam int XS = 20;
   localparam int VC = 30;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_notify_n, irq, err;
   logic [7:0] paddr, notify_count;
   logic [31:0] pwdata, prdata, rd;
   radio_in_type rin;
   rf_state_type rf_state;
   int bad_count, checks;
   radio_irq_event #(.XTAL_STAB_CYC(XS), .VCO_CAL_CYC(VC), .RF_WAKE_CYC(40)) radio_irq_event_i (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rin(rin), .irq_notify_n(irq_notify_n), .irq(irq), .rf_state(rf_state));
   host_irq_watch host_irq_watch_i (.pclk(pclk), .presetn(presetn),
      .irq_notify_n(irq_notify_n), .notify_count(notify_count));
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         chk("pready", 32'h0, 32'h1);
         wrap_up();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic line_is(input string nm, input logic v);
      @(posedge pclk);
      #1;
      chk(nm, 32'(irq_notify_n), 32'(v));
      @(posedge pclk);
   endtask
   task automatic wait_low(input int lim, output int n);
      n = 0;
      while (irq_notify_n !== 1'b0) begin
         @(posedge pclk);
         #1;
         n++;
         if (n > lim) begin
            chk("notify timeout", 32'h0, 32'h1);
            wrap_up();
         end
      end
      @(posedge pclk);
   endtask
   task automatic clr(input int b);
      apb(1'b1, OFS_EN_A, 32'h0);
      apb(1'b1, OFS_SRC_A, 32'h1 << b);
      line_is("cleared line", 1'b1);
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_stab;
      repeat (XS + 4) @(posedge pclk);
      apb(1'b0, OFS_SRC_A, 32'h0);
      chk("held while masked", rd, 32'h1);
      chk("masked line", 32'(irq_notify_n), 32'h1);
      apb(1'b1, OFS_EN_A, 32'h1);
      line_is("enable pending", 1'b0);
      clr(0);
      apb(1'b0, OFS_SRC_A, 32'h0);
      chk("src after clear", rd, 32'h0);
   endtask
   task automatic t_ev(input string nm, input logic [3:0] cmd, input int b, input int cyc);
      int n;
      apb(1'b1, OFS_EN_A, 32'h1 << b);
      apb(1'b1, OFS_CMD, {28'h0, cmd});
      wait_low(cyc + 10, n);
      // The delay counts from the setup edge of the command write.
      chk(nm, 32'(n), 32'(cyc - 2));
      clr(b);
   endtask
   task automatic t_pll;
      int n;
      apb(1'b1, OFS_EN_A, 32'h4);
      rin.pll_unlock <= 1'b1;
      @(posedge pclk);
      rin.pll_unlock <= 1'b0;
      line_is("unlock unarmed", 1'b1);
      rin.power_amp_on <= 1'b1;
      @(posedge pclk);
      rin.pll_unlock <= 1'b1;
      @(posedge pclk);
      rin.pll_unlock <= 1'b0;
      wait_low(3, n);
      clr(2);
      rin.power_amp_on <= 1'b0;
      apb(1'b1, OFS_EN_A, 32'h4);
      rin.vco_range_bad <= 1'b1;
      rin.power_amp_on <= 1'b1;
      @(posedge pclk);
      rin.vco_range_bad <= 1'b0;
      wait_low(3, n);
      clr(2);
      rin.power_amp_on <= 1'b0;
   endtask
   task automatic frame(input logic [7:0] len, input logic crc_blk);
      rin.sync_detect <= 1'b1;
      @(posedge pclk);
      rin.sync_detect <= 1'b0;
      for (int i = 0; i < 8 * (len + 1); i++) begin
         rin.rx_bit_tick <= 1'b1;
         rin.rx_bit <= (i < 8) ? len[7 - i] : 1'b0;
         rin.crc_block_done <= crc_blk && (i == 8 * len + 7);
         @(posedge pclk);
      end
      rin.rx_bit_tick <= 1'b0;
      rin.crc_block_done <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic t_rx;
      t_ev("rx on time", CMD_RX_ON, EV_RF_DONE, 2360);
      rin.rx_enable <= 1'b1;
      rin.fifo_level <= 7'h06;
      rin.host_fifo_write <= 1'b1;
      @(posedge pclk);
      rin.fifo_level <= 7'h01;
      rin.host_fifo_write <= 1'b0;
      rin.host_fifo_read <= 1'b1;
      @(posedge pclk);
      rin.host_fifo_read <= 1'b0;
      apb(1'b0, OFS_SRC_A, 32'h0);
      chk("write over full level", 32'(rd[EV_FULL]), 32'h1);
      chk("read under empty level", 32'(rd[EV_EMPTY]), 32'h1);
      apb(1'b1, OFS_SRC_A, 32'h30);
      frame(8'h01, 1'b1);
      apb(1'b0, OFS_SRC_A, 32'h0);
      chk("no full before level", 32'(rd[EV_FULL]), 32'h0);
      apb(1'b0, OFS_SRC_B, 32'h0);
      chk("rx done", 32'(rd[0]), 32'h1);
      chk("block crc error", 32'(rd[1]), 32'h1);
      apb(1'b1, OFS_SRC_B, 32'h3);
      apb(1'b1, OFS_CTRL, CTRL_RST | (32'(FMT_C) << CTRL_FMT_LSB));
      frame(8'h04, 1'b0);
      apb(1'b0, OFS_SRC_A, 32'h0);
      chk("full at level", 32'(rd[EV_FULL]), 32'h1);
      apb(1'b0, OFS_SRC_B, 32'h0);
      chk("format c done and crc", rd, 32'h3);
      apb(1'b1, OFS_SRC_B, 32'h3);
      t_ev("off from rx time", CMD_RADIO_OFF, EV_RF_DONE, 100);
      rin.rx_enable <= 1'b0;
   endtask
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      rin = '0;
      bad_count = 0;
      checks = 0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      t_stab();
      t_ev("vco cal time", CMD_VCO_CAL, EV_VCO_CAL, VC);
      t_ev("tx on time", CMD_TX_ON, EV_RF_DONE, 2860);
      chk("rf state tx", 32'(rf_state), 32'(RF_TX));
      apb(1'b0, OFS_SRC_A, 32'h0);
      chk("tx empty level", 32'(rd[EV_EMPTY]), 32'h1);
      apb(1'b1, OFS_SRC_A, 32'h1 << EV_EMPTY);
      t_pll();
      t_ev("off from tx time", CMD_RADIO_OFF, EV_RF_DONE, 480);
      t_rx();
      t_ev("clock cal time", CMD_CLK_CAL, EV_CLK_CAL, 101);
      t_ev("wake time", CMD_SLEEP, EV_WAKE, 101);
      apb(1'b0, 8'h3c, 32'h0);
      chk("unmapped error", 32'(err), 32'h1);
      apb(1'b1, OFS_CTRL, CTRL_RST | (32'h1 << CTRL_TCXO_BIT));
      repeat (XS) @(posedge pclk);
      apb(1'b1, OFS_SRC_A, 32'h1);
      t_ev("tcxo stable time", CMD_REF_OSC, EV_CLK_STAB, 200);
      chk("notifications", 32'(notify_count), 32'hb);
      wrap_up();
   end
endmodule
